// *** gsc_pkg.sv ***
package gsc_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_CNT_LO   = 8'h00;
    localparam logic [7:0] OFS_CNT_HI   = 8'h04;
    localparam logic [7:0] OFS_CTRL     = 8'h08;
    localparam logic [7:0] OFS_GCTRL    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
    localparam logic [7:0] OFS_CORE_IE  = 8'h18;

    // counter_control fields
    localparam int CTRL_CSS_HI = 7;
    localparam int CTRL_CSS_LO = 6;
    localparam int CTRL_PS_HI  = 5;
    localparam int CTRL_PS_LO  = 4;
    localparam int CTRL_OSC    = 3;
    localparam int CTRL_SYNC   = 2;
    localparam int CTRL_ON     = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hFD;

    // counter_gate_control fields
    localparam int GCTRL_GE     = 7;
    localparam int GCTRL_POL    = 6;
    localparam int GCTRL_VAL    = 2;
    localparam int GCTRL_GSS_HI = 1;
    localparam int GCTRL_GSS_LO = 0;
    localparam logic [7:0] GCTRL_WMASK = 8'hC3;

    // interrupt fields
    localparam int IRQ_OVF_BIT = 0;
    localparam int CORE_GIE    = 7;
    localparam int CORE_PERIPHERAL_IRQ_ENABLE   = 6;

    // reset values and the count maximum
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [7:0]  GCTRL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // clock source encodings
    localparam logic [1:0] CSS_INSTR = 2'h0;
    localparam logic [1:0] CSS_SYS   = 2'h1;

    // timing
    localparam int MCLK_HZ      = 50000000;
    localparam int INSTR_HZ     = 12500000;
    localparam int INSTR_CYCLES = MCLK_HZ / INSTR_HZ;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } gsc_sync_t;

    typedef struct packed {
        logic [15:0] count;
        logic [2:0]  presc;
        logic [7:0]  ctrl;
        logic [7:0]  gctrl;
        logic        ovf_flag;
        logic        ovf_ie;
        logic        glob_ie;
        logic        peri_ie;
        logic [1:0]  phase;
        logic        ext_prev;
        logic        ext_pend;
        logic [7:0]  rdata;
    } gsc_state_t;

endpackage : gsc_pkg

// *** gsc_sync3.sv ***
`timescale 1ns/10ps
module gsc_sync3
    import gsc_pkg::*;
(
    // clock and reset
    input  wire logic MCLK,
    input  wire logic RST,
    // asynchronous input and its settled level
    input  wire logic ASYNC_IN,
    output logic      LEVEL
);

    gsc_sync_t s_r;
    gsc_sync_t s_nxt;

    // the level moves only once the last two stages agree
    always_comb begin
        s_nxt     = s_r;
        s_nxt.ff1 = ASYNC_IN;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        if (s_r.ff2 == s_r.ff3) begin
            s_nxt.level = s_r.ff3;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign LEVEL = s_r.level;

endmodule : gsc_sync3

// *** gsc_counter.sv ***
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module gsc_counter
    import gsc_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // counter and gate pins
    input  wire logic        COUNT_PIN,
    input  wire logic        CRYSTAL_IN_PIN,
    input  wire logic        GATE_INPUT,
    input  wire logic [2:0]  GATE_SRC,
    // power state and oscillator
    input  wire logic        SLEEP,
    output logic             LOW_POWER_OSC_RUN,
    // interrupt
    output logic             IRQ,
    output logic             WAKE
);

    gsc_state_t s_r;
    gsc_state_t s_nxt;

    logic       pin_lvl;
    logic       xtal_lvl;
    logic       gate_pin_lvl;
    logic       setup_ph;
    logic       access_ph;
    logic       wr_acc;
    logic       rd_acc;
    logic       mapped;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;
    logic [1:0] css;
    logic [1:0] ps;
    logic       sync_mode;
    logic       instr_tick;
    logic       ext_lvl;
    logic       ext_rise;
    logic       src_tick;
    logic       gate_lvl;
    logic       permit;
    logic       step;
    logic       inc;
    logic [2:0] ps_mask;
    logic       wr_cnt;

    // external inputs cross into the MCLK domain
    gsc_sync3 u_sync_pin (
        .MCLK     (MCLK),
        .RST      (RST),
        .ASYNC_IN (COUNT_PIN),
        .LEVEL    (pin_lvl)
    );

    gsc_sync3 u_sync_xtal (
        .MCLK     (MCLK),
        .RST      (RST),
        .ASYNC_IN (CRYSTAL_IN_PIN),
        .LEVEL    (xtal_lvl)
    );

    gsc_sync3 u_sync_gate (
        .MCLK     (MCLK),
        .RST      (RST),
        .ASYNC_IN (GATE_INPUT),
        .LEVEL    (gate_pin_lvl)
    );

    // bus decode: zero wait states, read data caught in the setup cycle
    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign wr_acc    = access_ph && PWRITE;
    assign rd_acc    = access_ph && !PWRITE;
    assign wbyte     = PWDATA[7:0];
    assign mapped    = (PADDR == OFS_CNT_LO) || (PADDR == OFS_CNT_HI)
                    || (PADDR == OFS_CTRL) || (PADDR == OFS_GCTRL)
                    || (PADDR == OFS_IRQ_EN) || (PADDR == OFS_IRQ_FLAG)
                    || (PADDR == OFS_CORE_IE);
    assign wr_cnt    = wr_acc
                    && (PADDR == OFS_CNT_LO || PADDR == OFS_CNT_HI);

    // counter clock selection
    assign css        = s_r.ctrl[CTRL_CSS_HI:CTRL_CSS_LO];
    assign ps         = s_r.ctrl[CTRL_PS_HI:CTRL_PS_LO];
    assign sync_mode  = !s_r.ctrl[CTRL_SYNC];
    assign instr_tick = (s_r.phase == 2'(INSTR_CYCLES - 1)) && !SLEEP;
    assign ext_lvl    = s_r.ctrl[CTRL_OSC] ? xtal_lvl : pin_lvl;
    assign ext_rise   = ext_lvl && !s_r.ext_prev;

    always_comb begin
        case (css)
            CSS_INSTR: src_tick = instr_tick;
            CSS_SYS:   src_tick = !SLEEP;
            default: begin
                if (sync_mode) begin
                    // aligned to the instruction phase, stops in sleep
                    src_tick = (ext_rise || s_r.ext_pend) && instr_tick;
                end else begin
                    // unaligned, keeps going while the core sleeps
                    src_tick = ext_rise;
                end
            end
        endcase
    end

    // gate: pin or one of three internal sources, then polarity
    assign gate_lvl = {GATE_SRC, gate_pin_lvl}
                      [s_r.gctrl[GCTRL_GSS_HI:GCTRL_GSS_LO]];
    assign permit   = !s_r.gctrl[GCTRL_GE]
                   || (gate_lvl == s_r.gctrl[GCTRL_POL]);

    // prescaler: a divide by 2^ps pulse out of a 3-bit step counter, cleared by count writes
    assign ps_mask = 3'((4'h1 << ps) - 4'h1);
    assign step    = s_r.ctrl[CTRL_ON] && permit && src_tick;
    assign inc     = step && ((s_r.presc & ps_mask) == ps_mask);

    always_comb begin
        case (PADDR)
            OFS_CNT_LO:   rd_mux = s_r.count[7:0];
            OFS_CNT_HI:   rd_mux = s_r.count[15:8];
            OFS_CTRL:     rd_mux = s_r.ctrl;
            OFS_GCTRL: begin
                rd_mux            = s_r.gctrl;
                rd_mux[GCTRL_VAL] = gate_lvl;
            end
            OFS_IRQ_EN: begin
                rd_mux              = 8'h00;
                rd_mux[IRQ_OVF_BIT] = s_r.ovf_ie;
            end
            OFS_IRQ_FLAG: begin
                rd_mux              = 8'h00;
                rd_mux[IRQ_OVF_BIT] = s_r.ovf_flag;
            end
            OFS_CORE_IE: begin
                rd_mux            = 8'h00;
                rd_mux[CORE_GIE]  = s_r.glob_ie;
                rd_mux[CORE_PERIPHERAL_IRQ_ENABLE] = s_r.peri_ie;
            end
            default:      rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.phase    = 2'(s_r.phase + 2'h1);
        if (s_r.phase == 2'(INSTR_CYCLES - 1)) begin
            s_nxt.phase = 2'h0;
        end
        if (SLEEP) begin
            s_nxt.phase = s_r.phase;
        end
        s_nxt.ext_prev = ext_lvl;
        // an edge seen off-phase waits for the next instruction tick;
        // leaving sync mode drops a waiting edge, entering it starts with none waiting
        if (!sync_mode || instr_tick) begin
            s_nxt.ext_pend = 1'b0;
        end else if (ext_rise) begin
            s_nxt.ext_pend = 1'b1;
        end
        if (step) begin
            s_nxt.presc = 3'(s_r.presc + 3'h1);
        end
        if (inc) begin
            s_nxt.count = 16'(s_r.count + 16'h0001);
        end
        // read clears only what was returned; a new overflow still lands
        if (rd_acc && PADDR == OFS_IRQ_FLAG && s_r.rdata[IRQ_OVF_BIT]) begin
            s_nxt.ovf_flag = 1'b0;
        end
        if (inc && s_r.count == COUNT_MAX) begin
            s_nxt.ovf_flag = 1'b1;
        end
        if (setup_ph) begin
            s_nxt.rdata = rd_mux;
        end
        if (wr_acc) begin
            case (PADDR)
                // a count byte write beats a coincident increment in that byte; the other byte still takes the increment
                OFS_CNT_LO: s_nxt.count[7:0]  = wbyte;
                OFS_CNT_HI: s_nxt.count[15:8] = wbyte;
                OFS_CTRL:   s_nxt.ctrl  = wbyte & CTRL_WMASK;
                OFS_GCTRL:  s_nxt.gctrl = wbyte & GCTRL_WMASK;
                OFS_IRQ_EN: s_nxt.ovf_ie = wbyte[IRQ_OVF_BIT];
                OFS_CORE_IE: begin
                    s_nxt.glob_ie = wbyte[CORE_GIE];
                    s_nxt.peri_ie = wbyte[CORE_PERIPHERAL_IRQ_ENABLE];
                end
                default: ;
            endcase
        end
        if (wr_cnt) begin
            s_nxt.presc = 3'h0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_r       <= '0;
            s_r.count <= COUNT_RST;
            s_r.ctrl  <= CTRL_RST;
            s_r.gctrl <= GCTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA            = {24'h000000, s_r.rdata};
    assign PREADY            = 1'b1;
    assign PSLVERR           = access_ph && !mapped;
    // oscillator enable ignores sleep on purpose
    assign LOW_POWER_OSC_RUN = s_r.ctrl[CTRL_OSC];
    assign IRQ  = s_r.ovf_flag && s_r.ovf_ie
               && s_r.glob_ie && s_r.peri_ie;
    // wake needs only the local enable, as the core may have irqs off
    assign WAKE = s_r.ovf_flag && s_r.ovf_ie;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_rd_setup_lo;
        setup_ph && !PWRITE && PADDR == OFS_CNT_LO;
    endsequence

    sequence s_cnt_write;
        wr_cnt;
    endsequence

    sequence s_async_sleep_edge;
        SLEEP && css[1] && !sync_mode && s_r.ctrl[CTRL_ON]
        && permit && ext_rise && ps == 2'h0 && !wr_acc;
    endsequence

    AST_PRESC_CLR: assert property (s_cnt_write |=> s_r.presc == 3'h0)
        else $error("prescaler not cleared by count write");

    AST_DIV8: assert property (inc && ps == 2'h3 |-> s_r.presc == 3'h7)
        else $error("divide by eight increment off phase");

    AST_OFF_HOLD: assert property (
        !s_r.ctrl[CTRL_ON] && !wr_acc |=> $stable(s_r.count))
        else $error("count moved while counter is off");

    AST_GATE_HOLD: assert property (
        s_r.gctrl[GCTRL_GE] && gate_lvl != s_r.gctrl[GCTRL_POL]
        && !wr_acc |=> $stable(s_r.count))
        else $error("count moved while gate blocks");

    AST_INC_CAUSE: assert property (
        inc |-> s_r.ctrl[CTRL_ON] && permit && src_tick)
        else $error("increment without enabled source edge");

    AST_OVF_WRAP: assert property (
        inc && s_r.count == COUNT_MAX && !wr_acc
        |=> s_r.ovf_flag && s_r.count == COUNT_RST)
        else $error("wrap did not set overflow flag");

    AST_IRQ_RISE: assert property (
        $rose(s_r.ovf_flag) && s_r.ovf_ie && s_r.glob_ie && s_r.peri_ie
        |-> IRQ && WAKE)
        else $error("enabled overflow raised no interrupt");

    AST_SYNC_ALIGN: assert property (
        inc && css[1] && sync_mode |-> s_r.phase == 2'(INSTR_CYCLES - 1))
        else $error("synchronous count off instruction phase");

    AST_SLEEP_COUNT: assert property (
        s_async_sleep_edge |=> s_r.count == $past(s_r.count) + 16'h0001)
        else $error("async counter stalled in sleep");

    AST_OSC_SLEEP: assert property (
        SLEEP && s_r.ctrl[CTRL_OSC] |-> LOW_POWER_OSC_RUN)
        else $error("oscillator stopped in sleep");

    AST_READ_LO: assert property (
        s_rd_setup_lo ##1 PENABLE |-> PRDATA[7:0] == $past(s_r.count[7:0]))
        else $error("count low byte read mismatch");

endmodule : gsc_counter

// *** gsc_counter_tb.sv ***
`timescale 1ns/10ps
module gsc_counter_tb;
    import gsc_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] mask;
        logic [7:0] exp;
    } gsc_row_t;

    logic        MCLK;
    logic        RST;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        COUNT_PIN;
    logic        CRYSTAL_IN_PIN;
    logic        GATE_INPUT;
    logic [2:0]  GATE_SRC;
    logic        SLEEP;
    logic        LOW_POWER_OSC_RUN;
    logic        IRQ;
    logic        WAKE;
    int          n_mismatch;
    int          n_checks;
    int          pin_sel;
    int          e;
    logic [31:0] rd;
    logic        err;
    logic        lv;
    logic [2:0]  gs;
    logic [15:0] cnt;
    logic [15:0] held;
    gsc_row_t    rows [11];

    gsc_counter uut (
        .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .COUNT_PIN(COUNT_PIN), .CRYSTAL_IN_PIN(CRYSTAL_IN_PIN),
        .GATE_INPUT(GATE_INPUT), .GATE_SRC(GATE_SRC), .SLEEP(SLEEP),
        .LOW_POWER_OSC_RUN(LOW_POWER_OSC_RUN), .IRQ(IRQ), .WAKE(WAKE)
    );

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // request held until pready is sampled high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge MCLK);
            if (PREADY === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            test_done();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    // counter is stopped first: a byte pair read while running may tear
    task rd_count;
        apb(1'b0, OFS_CNT_LO, 8'h00);
        cnt[7:0] = rd[7:0];
        apb(1'b0, OFS_CNT_HI, 8'h00);
        cnt[15:8] = rd[7:0];
    endtask : rd_count

    // count bytes are only written while the counter is stopped
    task run(input logic [7:0] c, input int n);
        apb(1'b1, OFS_CNT_LO, 8'h00);
        apb(1'b1, OFS_CNT_HI, 8'h00);
        apb(1'b1, OFS_CTRL, c);
        repeat (n) begin
            repeat (8) @(posedge MCLK);
            if (pin_sel == 1) COUNT_PIN <= ~COUNT_PIN;
            if (pin_sel == 2) CRYSTAL_IN_PIN <= ~CRYSTAL_IN_PIN;
        end
        repeat (8) @(posedge MCLK);
        apb(1'b1, OFS_CTRL, 8'h00);
        rd_count();
    endtask : run

    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h00000000;
        COUNT_PIN = 1'b0;
        CRYSTAL_IN_PIN = 1'b0;
        GATE_INPUT = 1'b0;
        GATE_SRC = 3'h0;
        SLEEP = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        pin_sel = 0;
        rows = '{'{OFS_CTRL, 8'hFC, 8'hFF, 8'hFC},
                 '{OFS_CTRL, 8'hFF, 8'hFF, 8'hFD},
                 '{OFS_CTRL, 8'h00, 8'hFF, 8'h00},
                 '{OFS_GCTRL, 8'hFF, 8'hFB, 8'hC3},
                 '{OFS_GCTRL, 8'h00, 8'hFB, 8'h00},
                 '{OFS_IRQ_EN, 8'hFF, 8'h01, 8'h01},
                 '{OFS_CORE_IE, 8'hFF, 8'hC0, 8'hC0},
                 '{OFS_CNT_LO, 8'hA5, 8'hFF, 8'hA5},
                 '{OFS_CNT_HI, 8'h5A, 8'hFF, 8'h5A},
                 '{OFS_IRQ_FLAG, 8'hFF, 8'hFF, 8'h00},
                 '{8'h1C, 8'h77, 8'hFF, 8'h00}};
        repeat (20) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        check({29'h0, IRQ, WAKE, LOW_POWER_OSC_RUN}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 8'h00);
            check(rd, 32'h0);
        end
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            check({31'h0, err}, {31'h0, rows[i].addr == 8'h1C});
            apb(1'b0, rows[i].addr, 8'h00);
            check(rd & {24'hFFFFFF, rows[i].mask}, {24'h0, rows[i].exp});
        end
        apb(1'b1, OFS_CTRL, 8'h08);
        #1;
        check({31'h0, LOW_POWER_OSC_RUN}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            run({2'h1, 2'(i), 4'h1}, 8);
            e = 74 >> i;
            check({31'h0, int'(cnt) >= e - 2 && int'(cnt) <= e + 2}, 1);
        end
        held = cnt;
        repeat (20) @(posedge MCLK);
        rd_count();
        check({16'h0, cnt}, {16'h0, held});
        // high byte writes every third cycle keep the divide-by-8 at bay
        apb(1'b1, OFS_CNT_LO, 8'h00);
        apb(1'b1, OFS_CTRL, 8'h71);
        for (int i = 0; i < 10; i++) apb(1'b1, OFS_CNT_HI, 8'h00);
        apb(1'b1, OFS_CTRL, 8'h00);
        rd_count();
        check({16'h0, cnt}, 32'h0);
        apb(1'b1, OFS_IRQ_EN, 8'h01);
        apb(1'b1, OFS_CORE_IE, 8'hC0);
        apb(1'b1, OFS_CNT_LO, 8'hF0);
        apb(1'b1, OFS_CNT_HI, 8'hFF);
        apb(1'b1, OFS_CTRL, 8'h41);
        for (e = 0; e < 200 && IRQ !== 1'b1; e++) @(posedge MCLK);
        if (e == 200) begin
            n_mismatch++;
            test_done();
        end
        check({30'h0, IRQ, WAKE}, 32'h3);
        apb(1'b1, OFS_CTRL, 8'h00);
        apb(1'b0, OFS_IRQ_FLAG, 8'h00);
        check(rd, 32'h1);
        apb(1'b0, OFS_IRQ_FLAG, 8'h00);
        #1;
        check({rd[30:0], IRQ}, 32'h0);
        apb(1'b1, OFS_CORE_IE, 8'h00);
        apb(1'b1, OFS_CNT_LO, 8'hF0);
        apb(1'b1, OFS_CNT_HI, 8'hFF);
        apb(1'b1, OFS_CTRL, 8'h41);
        repeat (40) @(posedge MCLK);
        apb(1'b1, OFS_CTRL, 8'h00);
        #1;
        check({30'h0, IRQ, WAKE}, 32'h1);
        apb(1'b1, OFS_IRQ_EN, 8'h00);
        #1;
        check({31'h0, WAKE}, 32'h0);
        apb(1'b0, OFS_IRQ_FLAG, 8'h00);
        check(rd, 32'h1);
        // start-up delay: preset FC00 gives 1024 ticks to overflow
        apb(1'b1, OFS_IRQ_EN, 8'h01);
        apb(1'b1, OFS_CNT_LO, 8'h00);
        apb(1'b1, OFS_CNT_HI, 8'hFC);
        apb(1'b1, OFS_CTRL, 8'h41);
        for (e = 0; e < 1100 && WAKE !== 1'b1; e++) begin
            @(posedge MCLK);
            #1;
        end
        if (e == 1100) begin
            n_mismatch++;
            test_done();
        end
        check(e, 1024);
        apb(1'b1, OFS_CTRL, 8'h00);
        apb(1'b0, OFS_IRQ_FLAG, 8'h00);
        check(rd, 32'h1);
        apb(1'b1, OFS_IRQ_EN, 8'h00);
        GATE_INPUT <= 1'b1;
        apb(1'b1, OFS_GCTRL, 8'h80);
        run(8'h41, 4);
        check({16'h0, cnt}, 32'h0);
        GATE_INPUT <= 1'b0;
        run(8'h41, 4);
        check({31'h0, cnt != 0}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            lv = i[0];
            gs = {3{~lv}};
            if (i > 1) gs[i / 2 - 1] = lv;
            GATE_INPUT <= (i < 2) ? lv : ~lv;
            GATE_SRC <= gs;
            apb(1'b1, OFS_GCTRL, {6'h30, 2'(i / 2)});
            run(8'h41, 4);
            check({31'h0, cnt != 0}, {31'h0, lv});
        end
        apb(1'b1, OFS_GCTRL, 8'h00);
        pin_sel = 1;
        SLEEP <= 1'b1;
        run(8'h85, 20);
        check({16'h0, cnt}, 32'hA);
        run(8'h81, 20);
        check({16'h0, cnt}, 32'h0);
        SLEEP <= 1'b0;
        run(8'h81, 20);
        check({16'h0, cnt}, 32'hA);
        pin_sel = 2;
        run(8'h8D, 20);
        check({16'h0, cnt}, 32'hA);
        test_done();
    end

    // whole-run guard against a hang anywhere above
    initial begin
        #1ms;
        n_mismatch++;
        test_done();
    end
endmodule : gsc_counter_tb
